//--- common/rta_pkg.sv
// shared constants for the thermometer, clock/calendar and alarm core
package rta_pkg;
	// apb address layout: command code and byte index fields of paddr
	localparam int ADDR_W = 16;
	localparam int CMD_LSB = 7;
	localparam int IDX_LSB = 2;
	// command codes
	localparam logic [7:0] CMD_TEMP = 8'haa;
	localparam logic [7:0] CMD_COUNT = 8'ha8;
	localparam logic [7:0] CMD_SLOPE = 8'ha9;
	localparam logic [7:0] CMD_HIGH = 8'ha1;
	localparam logic [7:0] CMD_LOW = 8'ha2;
	localparam logic [7:0] CMD_TIME = 8'hc0;
	localparam logic [7:0] CMD_TALARM = 8'hc7;
	localparam logic [7:0] CMD_SRAM = 8'h17;
	localparam logic [7:0] CMD_CONFIG = 8'h3c;
	localparam logic [7:0] CMD_START = 8'h5a;
	// byte indices inside a command window
	localparam logic [4:0] IDX_SRAM_DATA = 5'h00;
	localparam logic [4:0] IDX_SRAM_PTR = 5'h01;
	localparam logic [4:0] IDX_SRAM_LAST = 5'h1f;
	localparam int TIME_BYTES = 7;
	localparam int TALARM_BYTES = 4;
	// time byte positions
	localparam int T_SEC = 0;
	localparam int T_MIN = 1;
	localparam int T_HOUR = 2;
	localparam int T_DAY = 3;
	localparam int T_DATE = 4;
	localparam int T_MON = 5;
	localparam int T_YEAR = 6;
	localparam int HALT_BIT = 7;
	localparam int MODE12_BIT = 6;
	localparam int PM_BIT = 5;
	// configuration field positions
	localparam int CFG_ONESHOT = 0;
	localparam int CFG_SRC_LSB = 1;
	localparam int CFG_POL = 3;
	localparam int CFG_OSC_EN = 4;
	localparam int CFG_DIV_LSB = 5;
	localparam int CFG_TFLAG = 7;
	localparam int CFG_CFLAG = 8;
	localparam int CFG_BUSY = 9;
	localparam logic [6:0] CFG_RESET = 7'h10;
	// alarm source selections
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_THERM = 2'h1;
	localparam logic [1:0] SRC_TIME = 2'h2;
	localparam logic [1:0] SRC_EITHER = 2'h3;
	// temperature format and limits in half degrees
	localparam int TEMP_PAD = 7;
	localparam logic signed [8:0] TEMP_MIN = -9'sd110;
	localparam logic signed [8:0] TEMP_MAX = 9'sd250;
	localparam logic [8:0] HIGH_RESET = 9'h050;
	localparam logic [8:0] LOW_RESET = 9'h03c;
	// crystal divide to one hertz
	localparam int XTAL_HZ = 32768;
	localparam logic [14:0] PRESCALE_LAST = 15'(XTAL_HZ - 1);
	// clock and conversion timing
	localparam int CLK_NS = 8;
	localparam int CONV_NS = 8000;
	localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;
	// reset values of clock and alarm bytes (12 am sunday, 12-hour mode)
	localparam logic [7:0] HOUR_RESET = 8'h52;
	localparam logic [7:0] ONE_BCD = 8'h01;
	// conversion states
	typedef enum logic [1:0] {
		RTA_IDLE = 2'b01,
		RTA_CONV = 2'b10
	} rta_conv_e;
endpackage

//--- src/rta_core.sv
// thermometer, bcd clock/calendar, alarms, clock divider and scratch sram behind apb
// Functional notes
// - convert continuously from reset without commands
// - temperature read returns last result, undisturbed
// - configuration picks continuous or one-shot conversion
// - read-temperature code returns last completed result
// - nine-bit two's complement, half degree, msb first
// - results clamped to minus 55 .. plus 125
// - counter code returns eight-bit residual count
// - slope code returns eight-bit counts per degree
// - bcd seconds through year from crystal timebase
// - short months and leap years through 2100
// - 12 or 24 hour, 12 at reset, am/pm
// - halt bit stops timekeeping oscillator
// - crystal divided, driven on divided clock output
// - configuration enables output and picks divider
// - alarm source none/thermal/time/either, none at reset
// - thermal alarm sets when temperature >= high limit
// - thermal alarm holds until <= low limit
// - time alarm sets at programmed second, minute, hour and day of week
// - time or alarm register access clears time alarm
// - configuration sets alarm pin active polarity
// - 32 scratch bytes with no side effects
// - msb first, one unique code per register
// - time at c0h, halt change after transfer ends
// - high/low limits at a1h/a2h, temperature format
// - sram at 17h, pointer wraps 1fh to 00h
// - either source: pin is or of both flags
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module rta_core import rta_pkg::*; (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter front end, same clock, sampled at end of conversion
	input wire logic [8:0] sensor_temp,
	input wire logic [7:0] sensor_remain,
	input wire logic [7:0] sensor_slope,
	output logic conv_busy,
	// crystal pins
	input wire logic crystal_input,
	output logic crystal_feedback,
	// open-drain alarm pin
	output logic alarm_output_pin,
	output logic alarm_output_pin_oe,
	// open-drain divided clock pin
	output logic divided_clock_output,
	output logic divided_clock_output_oe
);
	// bcd increment with wrap: {carry, next}
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] maxv,
		input logic [7:0] minv);
		if (v >= maxv) begin
			return {1'b1, minv};
		end else if (v[3:0] == 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			return {1'b0, v + 8'h01};
		end
	endfunction

	// hour increment in either mode: {carry to day, next}
	function automatic logic [8:0] hour_inc(input logic [7:0] h);
		logic [8:0] r;
		r = {1'b0, h};
		if (h[MODE12_BIT]) begin
			// 12-hour: 12 -> 01, 11 -> 12 toggles pm, day carries at midnight
			if (h[4:0] == 5'h12) begin
				r = {1'b0, h[7:5], 5'h01};
			end else if (h[4:0] == 5'h11) begin
				r = {h[PM_BIT], h[7:6], ~h[PM_BIT], 5'h12};
			end else begin
				r = {1'b0, h[7:5], 5'(bcd_inc({3'h0, h[4:0]}, 8'h12, 8'h01))};
			end
		end else begin
			// 24-hour
			r = {1'b0, h[7:6], 6'h00};
			if (h[5:0] != 6'h23) begin
				r = {1'b0, h[7:6], 6'(bcd_inc({2'h0, h[5:0]}, 8'h23, 8'h00))};
			end else begin
				r[8] = 1'b1;
			end
		end
		return r;
	endfunction

	// last date of a month in bcd; year 00 counts as leap, valid to 2100
	function automatic logic [7:0] month_end(input logic [7:0] mo, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mo)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// writable bits of each time or alarm byte
	function automatic logic [7:0] byte_mask(input int i);
		case (i)
			T_DAY: return 8'h07;
			T_DATE: return 8'h3f;
			T_MON: return 8'h1f;
			T_YEAR: return 8'hff;
			default: return 8'h7f;
		endcase
	endfunction

	// clamp a sensor reading into the reportable span
	function automatic logic [8:0] clamp_temp(input logic [8:0] t);
		if ($signed(t) < TEMP_MIN) begin
			return TEMP_MIN;
		end else if ($signed(t) > TEMP_MAX) begin
			return TEMP_MAX;
		end else begin
			return t;
		end
	endfunction

	// decoded address fields
	logic [7:0] cmd; // command code field
	logic [4:0] idx; // byte index field
	logic setup; // setup phase of a transfer
	logic done; // access phase completing
	logic known; // code and index are mapped
	logic wr; // completing write
	logic start_cmd; // one-shot start request
	assign cmd = paddr[CMD_LSB +: 8];
	assign idx = paddr[IDX_LSB +: 5];
	assign setup = psel & ~penable;
	assign done = psel & penable & pready;
	assign wr = done & pwrite & known;
	assign start_cmd = wr & (cmd == CMD_START);

	// state registers
	logic [6:0] cfg_q; // writable configuration bits
	logic [8:0] temp_q; // last completed temperature
	logic [7:0] remain_q; // residual slope count
	logic [7:0] slope_q; // counts per degree
	logic [8:0] high_q; // high trip limit
	logic [8:0] low_q; // low release limit
	logic therm_q; // thermal alarm flag
	logic tmatch_q; // time match flag
	logic [7:0] tm_q [TIME_BYTES]; // time bytes
	logic [7:0] al_q [TALARM_BYTES]; // alarm bytes
	logic halt_pend_q; // halt bit as written
	logic halt_q; // halt bit in force
	logic [7:0] sram [32]; // scratch bytes, no reset value
	logic [4:0] ptr_q; // scratch pointer
	logic [31:0] prdata_q; // read data caught in setup
	rta_conv_e state_q; // conversion state
	logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_q; // conversion timer
	logic conv_done; // conversion finishing this cycle
	logic [2:0] xtal_q; // crystal synchroniser and edge stage
	logic xtal_rise; // crystal rising edge
	logic [14:0] pre_q; // crystal prescaler
	logic sec_tick; // one-hertz tick
	logic [7:0] tm_n [TIME_BYTES]; // time after one second
	logic alarm_on; // selected alarm condition
	logic osc_q; // divided clock level
	logic tacc; // completing time or alarm access
	logic tset; // time alarm match on this tick

	// address map, answered in access phase
	always_comb begin
		known = 1'b0;
		case (cmd)
			CMD_TEMP, CMD_COUNT, CMD_SLOPE, CMD_HIGH, CMD_LOW,
			CMD_CONFIG, CMD_START: known = (idx == 5'h00);
			CMD_TIME: known = (int'(idx) < TIME_BYTES);
			CMD_TALARM: known = (int'(idx) < TALARM_BYTES);
			CMD_SRAM: known = (idx <= IDX_SRAM_PTR);
			default: known = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~known;
	assign prdata = prdata_q;

	// read data mux, caught at setup so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			prdata_q <= 32'h0;
			case (cmd)
				CMD_TEMP: prdata_q <= {16'h0, temp_q, 7'h0};
				CMD_COUNT: prdata_q <= {24'h0, remain_q};
				CMD_SLOPE: prdata_q <= {24'h0, slope_q};
				CMD_HIGH: prdata_q <= {16'h0, high_q, 7'h0};
				CMD_LOW: prdata_q <= {16'h0, low_q, 7'h0};
				CMD_CONFIG: prdata_q <= {22'h0, state_q == RTA_CONV, tmatch_q, therm_q, cfg_q};
				CMD_TIME: begin
					// seconds byte carries the halt bit on top
					if (idx == 5'h00) begin
						prdata_q <= {24'h0, halt_pend_q, tm_q[T_SEC][6:0]};
					end else if (int'(idx) < TIME_BYTES) begin
						prdata_q <= {24'h0, tm_q[3'(idx)]};
					end
				end
				CMD_TALARM: begin
					if (int'(idx) < TALARM_BYTES) begin
						prdata_q <= {24'h0, al_q[2'(idx)]};
					end
				end
				CMD_SRAM: begin
					if (idx == IDX_SRAM_DATA) begin
						prdata_q <= {24'h0, sram[ptr_q]};
					end else if (idx == IDX_SRAM_PTR) begin
						prdata_q <= {27'h0, ptr_q};
					end
				end
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	// configuration and limit registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CFG_RESET;
			high_q <= HIGH_RESET;
			low_q <= LOW_RESET;
		end else if (wr) begin
			case (cmd)
				CMD_CONFIG: cfg_q <= pwdata[6:0];
				CMD_HIGH: high_q <= pwdata[TEMP_PAD +: 9];
				CMD_LOW: low_q <= pwdata[TEMP_PAD +: 9];
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// conversion sequencer: continuous from reset, or one per start in one-shot
	assign conv_done = (state_q == RTA_CONV) && (conv_cnt_q == 0);
	assign conv_busy = (state_q == RTA_CONV);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= RTA_CONV;
			conv_cnt_q <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
		end else begin
			case (state_q)
				RTA_IDLE: begin
					// standby until continuous mode or a start request
					if (!cfg_q[CFG_ONESHOT] || start_cmd) begin
						state_q <= RTA_CONV;
						conv_cnt_q <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
					end
				end
				RTA_CONV: begin
					if (conv_cnt_q != 0) begin
						conv_cnt_q <= conv_cnt_q - 1'b1;
					end else if (cfg_q[CFG_ONESHOT]) begin
						state_q <= RTA_IDLE;
					end else begin
						// back to back conversions
						conv_cnt_q <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
					end
				end
				default: state_q <= RTA_IDLE;
			endcase
		end
	end

	// results change only when a conversion completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_q <= 9'h0;
			remain_q <= 8'h0;
			slope_q <= 8'h0;
		end else if (conv_done) begin
			temp_q <= clamp_temp(sensor_temp);
			remain_q <= sensor_remain;
			slope_q <= sensor_slope;
		end
	end

	// thermal flag with hysteresis, updated after each conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_q <= 1'b0;
		end else if (conv_done) begin
			if ($signed(clamp_temp(sensor_temp)) >= $signed(high_q)) begin
				therm_q <= 1'b1;
			end else if ($signed(clamp_temp(sensor_temp)) <= $signed(low_q)) begin
				therm_q <= 1'b0;
			end
		end
	end

	// crystal synchroniser; only the second and third stages feed logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_q <= 3'h0;
		end else begin
			xtal_q <= {xtal_q[1:0], crystal_input};
		end
	end
	assign xtal_rise = xtal_q[1] & ~xtal_q[2];

	// prescaler stops while halted; its top gives the one-hertz tick
	assign sec_tick = xtal_rise & ~halt_q & (pre_q == PRESCALE_LAST);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 15'h0;
		end else if (xtal_rise && !halt_q) begin
			pre_q <= (pre_q == PRESCALE_LAST) ? 15'h0 : pre_q + 15'h1;
		end
	end

	// halt change takes effect once the transfer has ended
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_pend_q <= 1'b0;
			halt_q <= 1'b0;
		end else begin
			halt_q <= halt_pend_q;
			if (wr && cmd == CMD_TIME && idx == 5'h00) begin
				halt_pend_q <= pwdata[HALT_BIT];
			end
		end
	end

	// calendar ripple for one second
	always_comb begin
		logic [8:0] s;
		logic [8:0] m;
		logic [8:0] h;
		logic [8:0] d;
		logic [8:0] mo;
		logic [8:0] y;
		logic [8:0] dw;
		s = bcd_inc(tm_q[T_SEC], 8'h59, 8'h00);
		m = bcd_inc(tm_q[T_MIN], 8'h59, 8'h00);
		h = hour_inc(tm_q[T_HOUR]);
		d = bcd_inc(tm_q[T_DATE], month_end(tm_q[T_MON], tm_q[T_YEAR]), ONE_BCD);
		mo = bcd_inc(tm_q[T_MON], 8'h12, ONE_BCD);
		y = bcd_inc(tm_q[T_YEAR], 8'h99, 8'h00);
		dw = bcd_inc(tm_q[T_DAY], 8'h07, ONE_BCD); // day of week wraps 7 -> 1
		tm_n = tm_q;
		tm_n[T_SEC] = s[7:0];
		if (s[8]) begin
			tm_n[T_MIN] = m[7:0];
			if (m[8]) begin
				tm_n[T_HOUR] = h[7:0];
				if (h[8]) begin
					tm_n[T_DAY] = dw[7:0];
					tm_n[T_DATE] = d[7:0];
					if (d[8]) begin
						tm_n[T_MON] = mo[7:0];
						if (mo[8]) begin
							tm_n[T_YEAR] = y[7:0];
						end
					end
				end
			end
		end
	end

	// time and alarm byte storage, one per generated slot
	generate
		for (genvar i = 0; i < TIME_BYTES; i++) begin : g_time
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tm_q[i] <= (i == T_HOUR) ? HOUR_RESET
						: (i == T_DAY || i == T_DATE || i == T_MON) ? ONE_BCD : 8'h00;
				end else if (wr && cmd == CMD_TIME && int'(idx) == i) begin
					tm_q[i] <= pwdata[7:0] & byte_mask(i);
				end else if (sec_tick) begin
					tm_q[i] <= tm_n[i];
				end
			end
		end
		for (genvar j = 0; j < TALARM_BYTES; j++) begin : g_alarm
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					al_q[j] <= (j == T_HOUR) ? HOUR_RESET : (j == T_DAY) ? ONE_BCD : 8'h00;
				end else if (wr && cmd == CMD_TALARM && int'(idx) == j) begin
					al_q[j] <= pwdata[7:0] & byte_mask(j);
				end
			end
		end
	endgenerate

	// time match flag: a match on a tick beats an access clear
	assign tacc = done & known & (cmd == CMD_TIME || cmd == CMD_TALARM);
	assign tset = sec_tick && tm_n[T_SEC] == al_q[T_SEC] && tm_n[T_MIN] == al_q[T_MIN]
		&& tm_n[T_HOUR] == al_q[T_HOUR] && tm_n[T_DAY] == al_q[T_DAY];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmatch_q <= 1'b0;
		end else if (tset) begin
			tmatch_q <= 1'b1;
		end else if (tacc) begin
			tmatch_q <= 1'b0;
		end
	end

	// scratch bytes and wrapping pointer
	always_ff @(posedge pclk) begin
		if (wr && cmd == CMD_SRAM && idx == IDX_SRAM_DATA) begin
			sram[ptr_q] <= pwdata[7:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= 5'h0;
		end else if (wr && cmd == CMD_SRAM && idx == IDX_SRAM_PTR) begin
			ptr_q <= pwdata[4:0];
		end else if (done && known && cmd == CMD_SRAM && idx == IDX_SRAM_DATA) begin
			ptr_q <= ptr_q + 5'h1;
		end
	end

	// alarm source select and pin polarity; open drain pulls when low is wanted
	always_comb begin
		case (cfg_q[CFG_SRC_LSB +: 2])
			SRC_THERM: alarm_on = therm_q;
			SRC_TIME: alarm_on = tmatch_q;
			SRC_EITHER: alarm_on = therm_q | tmatch_q;
			default: alarm_on = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_output_pin_oe <= 1'b0;
		end else begin
			alarm_output_pin_oe <= ~(alarm_on ^ ~cfg_q[CFG_POL]);
		end
	end
	assign alarm_output_pin = 1'b0;

	// divided crystal clock: prescaler tap picks /2, /4, /8 or /16
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q <= 1'b0;
			crystal_feedback <= 1'b0;
		end else begin
			osc_q <= cfg_q[CFG_OSC_EN] & ~pre_q[cfg_q[CFG_DIV_LSB +: 2]];
			crystal_feedback <= ~xtal_q[1] & ~halt_q;
		end
	end
	assign divided_clock_output = 1'b0;
	assign divided_clock_output_oe = osc_q;

	// checks
	property p_tmatch_clear;
		@(posedge pclk) disable iff (!presetn) (tacc && !tset) |=> !tmatch_q;
	endproperty
	a_tmatch_clear: assert property (p_tmatch_clear) else $error("time flag not cleared");
	property p_alarm_none;
		@(posedge pclk) disable iff (!presetn)
		(cfg_q[CFG_SRC_LSB +: 2] == SRC_NONE) |=> (alarm_output_pin_oe == $past(cfg_q[CFG_POL]));
	endproperty
	a_alarm_none: assert property (p_alarm_none) else $error("alarm pin active with no source");
	property p_therm_set;
		@(posedge pclk) disable iff (!presetn)
		(conv_done && $signed(clamp_temp(sensor_temp)) >= $signed(high_q)) |=> therm_q;
	endproperty
	a_therm_set: assert property (p_therm_set) else $error("thermal flag missed");
	property p_therm_hold;
		@(posedge pclk) disable iff (!presetn) (therm_q && !conv_done) |=> therm_q;
	endproperty
	a_therm_hold: assert property (p_therm_hold) else $error("thermal flag dropped");
	property p_temp_stable;
		@(posedge pclk) disable iff (!presetn) !conv_done |=> $stable(temp_q);
	endproperty
	a_temp_stable: assert property (p_temp_stable) else $error("result changed early");
	property p_oneshot;
		@(posedge pclk) disable iff (!presetn)
		(conv_done && cfg_q[CFG_ONESHOT]) |=> (state_q == RTA_IDLE);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not stand by");
	property p_clamp;
		@(posedge pclk) disable iff (!presetn)
		$signed(temp_q) >= TEMP_MIN && $signed(temp_q) <= TEMP_MAX;
	endproperty
	a_clamp: assert property (p_clamp) else $error("temperature out of span");
	property p_sram_wrap;
		@(posedge pclk) disable iff (!presetn)
		(done && cmd == CMD_SRAM && idx == IDX_SRAM_DATA && ptr_q == IDX_SRAM_LAST) |=> ptr_q == 5'h0;
	endproperty
	a_sram_wrap: assert property (p_sram_wrap) else $error("pointer did not wrap");
	property p_halt_tick;
		@(posedge pclk) disable iff (!presetn) halt_q |=> $stable(pre_q);
	endproperty
	a_halt_tick: assert property (p_halt_tick) else $error("clock ran while halted");
	property p_bad_cmd;
		@(posedge pclk) disable iff (!presetn)
		(done && !known) |=> $stable(cfg_q) && $stable(high_q) && $stable(low_q)
			&& !$fell(tmatch_q);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("unknown code changed state");
	property p_conv_run;
		@(posedge pclk) disable iff (!presetn)
		(state_q == RTA_IDLE && !cfg_q[CFG_ONESHOT]) |=> (state_q == RTA_CONV);
	endproperty
	a_conv_run: assert property (p_conv_run) else $error("continuous mode idle");
	c_conv: cover property (@(posedge pclk) disable iff (!presetn) conv_done);
	c_tmatch: cover property (@(posedge pclk) disable iff (!presetn) tset);
	c_therm: cover property (@(posedge pclk) disable iff (!presetn) $rose(therm_q));
	c_wrap: cover property (@(posedge pclk) disable iff (!presetn) $fell(ptr_q[4]));
endmodule

//--- verif/rta_front_model.sv
// converter front end and crystal model facing the core
`timescale 1ns/1ps
module rta_front_model #(
	parameter logic [7:0] REMAIN = 8'h0c,
	parameter logic [7:0] SLOPE = 8'h40
) (
	// clock and wanted reading
	input wire logic pclk,
	input wire logic [8:0] set_temp,
	// readings and crystal toward the core
	output logic [8:0] sensor_temp,
	output logic [7:0] sensor_remain,
	output logic [7:0] sensor_slope,
	output logic crystal_input
);
	logic [1:0] half_q = 2'h0; // crystal half period count
	initial crystal_input = 1'b0;
	// readings follow the wanted value one edge later
	always @(posedge pclk) begin
		sensor_temp <= set_temp;
		sensor_remain <= REMAIN;
		sensor_slope <= SLOPE;
	end
	// free running slow crystal, four pclk per half period
	always @(posedge pclk) begin
		half_q <= half_q + 2'h1;
		if (half_q == 2'h3) begin
			crystal_input <= ~crystal_input;
		end
	end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the thermometer, clock and alarm core
`timescale 1ns/1ps
module tb_top;
	import rta_pkg::*;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, conv_busy, crystal_input, crystal_feedback, last_err;
	logic alarm_output_pin, alarm_output_pin_oe;
	logic divided_clock_output, divided_clock_output_oe;
	logic [8:0] set_temp = 9'h1ce; // minus 25 degrees
	logic [8:0] sensor_temp;
	logic [7:0] sensor_remain, sensor_slope;
	int n_errors = 0;
	int tests_run = 0;
	always #4 pclk = ~pclk;
	rta_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sensor_temp, .sensor_remain, .sensor_slope, .conv_busy,
		.crystal_input, .crystal_feedback, .alarm_output_pin, .alarm_output_pin_oe,
		.divided_clock_output, .divided_clock_output_oe);
	rta_front_model i_front (.pclk, .set_temp, .sensor_temp, .sensor_remain, .sensor_slope,
		.crystal_input);
	// one apb transfer: setup, then access until pready
	task xfer(input logic w, input logic [7:0] c, input logic [4:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {1'b0, c, i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// compare and count
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// masked register read
	task rdchk(input logic [7:0] c, input logic [4:0] i, input logic [31:0] m,
		input logic [31:0] exp, input string nm);
		xfer(1'b0, c, i, 32'h0);
		chk(nm, exp, rd & m);
	endtask
	// let two whole conversions pass
	task settle;
		repeat (2 * CONV_CYCLES + 10) @(posedge pclk);
	endtask
	// alarm pin enable, sampled after registers settle
	task pinchk(input logic exp);
		repeat (3) @(posedge pclk);
		#1;
		chk("alarm pin", {31'h0, exp}, {31'h0, alarm_output_pin_oe});
	endtask
	// sample divided clock and crystal feedback levels; running means both levels seen
	task oscchk(input logic osc_runs, input logic fb_runs);
		logic [1:0] osc_seen;
		logic [1:0] fb_seen;
		osc_seen = 2'b00;
		fb_seen = 2'b00;
		repeat (200) begin
			@(posedge pclk);
			#1;
			osc_seen[divided_clock_output_oe] = 1'b1;
			fb_seen[crystal_feedback] = 1'b1;
		end
		chk("clock output", {31'h0, osc_runs}, {31'h0, &osc_seen});
		chk("crystal feedback", {31'h0, fb_runs}, {31'h0, &fb_seen});
	endtask
	task complete_run;
		if (n_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// watchdog against a hang, about twice the length of the tests
	initial begin
		repeat (40 * CONV_CYCLES) @(posedge pclk);
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(CMD_CONFIG, 5'h00, 32'h7f, 32'h10, "config");
		rdchk(CMD_HIGH, 5'h00, ALL, 32'h2800, "high");
		rdchk(CMD_LOW, 5'h00, ALL, 32'h1e00, "low");
		rdchk(CMD_TIME, 5'h02, ALL, 32'h52, "hour");
		oscchk(1'b1, 1'b1);
		xfer(1'b1, CMD_TIME, 5'h00, 32'h80);
		rdchk(CMD_TIME, 5'h00, ALL, 32'h80, "halt bit");
		oscchk(1'b0, 1'b0);
		xfer(1'b1, CMD_TIME, 5'h00, 32'h00);
		oscchk(1'b1, 1'b1);
		settle();
		rdchk(CMD_TEMP, 5'h00, ALL, 32'he700, "temp");
		rdchk(CMD_COUNT, 5'h00, ALL, 32'h0c, "residual");
		rdchk(CMD_SLOPE, 5'h00, ALL, 32'h40, "slope");
		set_temp <= 9'h0fb;
		settle();
		rdchk(CMD_TEMP, 5'h00, ALL, 32'h7d00, "clamped temp");
		xfer(1'b1, CMD_CONFIG, 5'h00, 32'h12);
		pinchk(1'b1);
		set_temp <= 9'h046;
		settle();
		rdchk(CMD_CONFIG, 5'h00, 32'h80, 32'h80, "flag held");
		set_temp <= 9'h03c;
		settle();
		rdchk(CMD_CONFIG, 5'h00, 32'h80, 32'h00, "flag released");
		xfer(1'b1, CMD_CONFIG, 5'h00, 32'h1a);
		pinchk(1'b1);
		set_temp <= 9'h050;
		settle();
		rdchk(CMD_CONFIG, 5'h00, 32'h80, 32'h80, "flag at limit");
		pinchk(1'b0);
		xfer(1'b1, 8'h33, 5'h00, 32'hff);
		chk("error", 32'h1, {31'h0, last_err});
		rdchk(CMD_CONFIG, 5'h00, 32'hff, 32'h9a, "config kept");
		xfer(1'b1, CMD_SRAM, IDX_SRAM_PTR, 32'h1f);
		xfer(1'b1, CMD_SRAM, IDX_SRAM_DATA, 32'ha5);
		xfer(1'b1, CMD_SRAM, IDX_SRAM_DATA, 32'h5a);
		rdchk(CMD_SRAM, IDX_SRAM_PTR, 32'hff, 32'h01, "pointer");
		xfer(1'b1, CMD_SRAM, IDX_SRAM_PTR, 32'h1f);
		rdchk(CMD_SRAM, IDX_SRAM_DATA, 32'hff, 32'ha5, "sram top");
		rdchk(CMD_SRAM, IDX_SRAM_DATA, 32'hff, 32'h5a, "sram wrap");
		xfer(1'b1, CMD_CONFIG, 5'h00, 32'h0b);
		settle();
		rdchk(CMD_CONFIG, 5'h00, 32'h27f, 32'h0b, "standby");
		chk("busy pin", 32'h0, {31'h0, conv_busy});
		oscchk(1'b0, 1'b1);
		set_temp <= 9'h032;
		settle();
		rdchk(CMD_TEMP, 5'h00, ALL, 32'h2800, "standby temp");
		xfer(1'b1, CMD_START, 5'h00, 32'h0);
		rdchk(CMD_CONFIG, 5'h00, 32'h200, 32'h200, "busy");
		chk("busy pin", 32'h1, {31'h0, conv_busy});
		settle();
		rdchk(CMD_TEMP, 5'h00, ALL, 32'h1900, "one-shot temp");
		complete_run();
	end
endmodule
